//--- design/ffs_accum.sv
// One first-order modulus accumulator stage of the noise-shaping modulator
`timescale 1ns/100ps
module ffs_accum (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    run,
  input  wire logic [ffs_pkg::FW-1:0]  modulus,
  input  wire logic [ffs_pkg::FW-1:0]  incr,
  output logic      [ffs_pkg::FW-1:0]  acc,
  output logic                         carry
);
  typedef struct packed {
    logic [ffs_pkg::FW-1:0] acc;
    logic                   carry;
  } ffs_acc_t;

  ffs_acc_t                s_q;
  ffs_acc_t                s_d;
  logic   [ffs_pkg::FW:0]  sum;

  // Wrap at the modulus; the carry marks each wrap
  // Modulus wrap of all three stages sets the sequence repeat length
  always_comb begin
    s_d = s_q;
    sum = {1'b0, s_q.acc} + {1'b0, incr};
    if (!run) begin
      s_d = '0;                       // Cleared so each run restarts the same sequence
    end else if (sum >= {1'b0, modulus}) begin
      s_d.acc   = sum[ffs_pkg::FW-1:0] - modulus;
      s_d.carry = 1'b1;
    end else begin
      s_d.acc   = sum[ffs_pkg::FW-1:0];
      s_d.carry = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign acc   = s_q.acc;
  assign carry = s_q.carry;

  // Stored residue stays below the modulus while the increment is below it
  acc_below_mod_a: assert property (@(posedge clock) disable iff (rst)
    run && incr < modulus && s_q.acc < modulus |=> s_q.acc < modulus)
    else $error("accumulator left modulus range");
endmodule : ffs_accum

//--- design/ffs_pkg.sv
// Package with constants and types for the fractional feedback modulator control block
//
// Behaviour
// - Integer feedback ratio is 80 plus the 6-bit field, giving 80 to 131; the code does not limit the field, so values 52 to 63 give up to 143.
// - Host writes acquire trigger 1 then 0; device then reruns band calibration.
// - After reset a calibration picks one of 32 bands from the integer ratio.
// - In fractional mode the modulator adds -4 to +3 to the ratio each cycle.
// - Modulator runs only while its powerdown bit is 0; 1 keeps it off.
// - Modulus is built from a 4-bit field plus the next full byte.
// - Numerator is built from a full byte plus the shared register's upper nibble.
// - Modulator steps once per reference cycle; resolution is reference over modulus.
// - Output sequence repeat length follows the modulus factors of 2, 3 and 6.
// - Loop bandwidth is 50 kHz normally, 125 kHz while spread is requested.
// - While the widest-loop pin is high the bandwidth is forced to 250 kHz.
// - Modulator logic runs on the reference clock and only in fractional mode.
// - Average division equals integer ratio plus numerator over modulus.
package ffs_pkg;
  localparam int          FW            = 12;     // Fraction and modulus width
  localparam logic [7:0]  NB_BASE       = 8'h50;  // Integer ratio offset, 80
  localparam logic [5:0]  NB_FIELD_MAX  = 6'h33;  // Field value for ratio 131
  // Register indices on the write port
  localparam logic [2:0]  IDX_FRAC_HI   = 3'h0;
  localparam logic [2:0]  IDX_FRAC_MOD  = 3'h1;
  localparam logic [2:0]  IDX_MOD_LO    = 3'h2;
  localparam logic [2:0]  IDX_INT_RATIO = 3'h3;
  localparam logic [2:0]  IDX_MOD_CTL   = 3'h4;
  localparam logic [2:0]  IDX_BLEED     = 3'h5;
  localparam logic [2:0]  IDX_ACQ       = 3'h6;
  localparam logic [2:0]  IDX_STATUS    = 3'h7;
  // Field positions
  localparam int          PD_BIT        = 4;      // modulator_powerdown
  localparam int          BLEED_BIT     = 2;
  localparam int          ACQ_BIT       = 0;      // acquire_trigger
  // Reset values
  localparam logic [7:0]  RST_ZERO      = 8'h00;
  localparam logic [7:0]  RST_MOD_CTL   = 8'h10;  // Modulator powered down
  // Modulator output limits
  localparam logic signed [5:0] OFS_MAX = 6'sh03;
  localparam logic signed [5:0] OFS_MIN = -6'sh04;
  // Band calibration: 32 bands, band = field * 5 / 8 maps 0..51 onto 0..31
  localparam logic [2:0]  BAND_MUL      = 3'h5;
  localparam int          BAND_SHIFT    = 3;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          CAL_TIME_NS   = 10000;  // Least calibration time
  localparam int          CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CAL_W         = 8;
  // Loop bandwidth codes
  typedef enum logic [1:0] {FFS_BW_50K, FFS_BW_125K, FFS_BW_250K} ffs_bw_t;
  typedef enum logic [0:0] {FFS_IDLE, FFS_CAL} ffs_cal_t;
endpackage : ffs_pkg

//--- design/ffs_top.sv
// Fractional feedback ratio control: registers, modulator, band calibration, bandwidth select
`timescale 1ns/100ps
module ffs_top (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic [2:0]  reg_idx,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        spread_request_pin,
  input  wire logic        widest_loop_pin,
  output logic      [7:0]  integer_feedback_ratio,
  output logic signed [3:0] modulator_offset,
  output logic             modulator_active,
  output logic             bleed_enable,
  output logic [1:0]       loop_bw_sel,
  output logic             cal_busy,
  output logic [4:0]       vco_band
);
  typedef struct packed {
    logic [7:0]              frac_hi;     // fraction_high_byte
    logic [7:0]              frac_mod;    // fraction_low_modulus_high
    logic [7:0]              mod_lo;      // modulus_low_byte
    logic [7:0]              int_ratio;   // integer_ratio_offset
    logic [7:0]              mod_ctl;     // modulator_control_reg
    logic [7:0]              bleed;       // bleed_control_reg
    logic [7:0]              acq;         // acquisition_control_reg
    logic                    armed;
    ffs_pkg::ffs_cal_t       cal;
    logic [ffs_pkg::CAL_W-1:0] cal_cnt;
    logic [4:0]              band;
    logic signed [3:0]       ofs;
    logic [2:0]              res;
    logic                    c2z;
    logic                    c3z;
    logic                    c3zz;
    logic [7:0]              ratio;
    ffs_pkg::ffs_bw_t        bw;
    logic [7:0]              rdata;
  } ffs_state_t;

  ffs_state_t                  s_q;
  ffs_state_t                  s_d;
  logic [ffs_pkg::FW-1:0]      frac_num;
  logic [ffs_pkg::FW-1:0]      frac_mod;
  logic [ffs_pkg::FW-1:0]      acc1;
  logic [ffs_pkg::FW-1:0]      acc2;
  logic                        c1;
  logic                        c2;
  logic                        c3;
  logic                        run;
  logic signed [5:0]           raw;
  logic signed [5:0]           tot;
  logic [5:0]                  field;
  logic [8:0]                  band_prod;

  // Field assembly from the split registers
  assign frac_num = {s_q.frac_hi, s_q.frac_mod[7:4]};
  assign frac_mod = {s_q.frac_mod[3:0], s_q.mod_lo};
  assign field    = s_q.int_ratio[5:0];
  // Fractional mode is the powered-up modulator
  assign run      = ~s_q.mod_ctl[ffs_pkg::PD_BIT];

  // Three cascaded stages, each stepping once per reference clock
  ffs_accum u_acc1 (
    .clock   (clock),
    .rst     (rst),
    .run     (run),
    .modulus (frac_mod),
    .incr    (frac_num),
    .acc     (acc1),
    .carry   (c1)
  );
  ffs_accum u_acc2 (
    .clock   (clock),
    .rst     (rst),
    .run     (run),
    .modulus (frac_mod),
    .incr    (acc1),
    .acc     (acc2),
    .carry   (c2)
  );
  ffs_accum u_acc3 (
    .clock   (clock),
    .rst     (rst),
    .run     (run),
    .modulus (frac_mod),
    .incr    (acc2),
    .acc     (),
    .carry   (c3)
  );

  // Next-state logic for registers, modulator output, calibration and bandwidth
  always_comb begin
    s_d = s_q;
    raw = '0;
    tot = '0;
    band_prod = '0;
    // Register writes
    if (reg_wr) begin
      case (reg_idx)
        ffs_pkg::IDX_FRAC_HI:   s_d.frac_hi   = reg_wdata;
        ffs_pkg::IDX_FRAC_MOD:  s_d.frac_mod  = reg_wdata;
        ffs_pkg::IDX_MOD_LO:    s_d.mod_lo    = reg_wdata;
        ffs_pkg::IDX_INT_RATIO: s_d.int_ratio = reg_wdata;
        ffs_pkg::IDX_MOD_CTL:   s_d.mod_ctl   = reg_wdata;
        ffs_pkg::IDX_BLEED:     s_d.bleed     = reg_wdata;
        ffs_pkg::IDX_ACQ:       s_d.acq       = reg_wdata;
        default: ;
      endcase
    end
    // Read data is registered; status shows calibration state and band
    case (reg_idx)
      ffs_pkg::IDX_FRAC_HI:   s_d.rdata = s_q.frac_hi;
      ffs_pkg::IDX_FRAC_MOD:  s_d.rdata = s_q.frac_mod;
      ffs_pkg::IDX_MOD_LO:    s_d.rdata = s_q.mod_lo;
      ffs_pkg::IDX_INT_RATIO: s_d.rdata = s_q.int_ratio;
      ffs_pkg::IDX_MOD_CTL:   s_d.rdata = s_q.mod_ctl;
      ffs_pkg::IDX_BLEED:     s_d.rdata = s_q.bleed;
      ffs_pkg::IDX_ACQ:       s_d.rdata = s_q.acq;
      default:                s_d.rdata = {2'b00, s_q.cal == ffs_pkg::FFS_CAL, s_q.band};
    endcase

    // Carry combination: c1 + d(c2) + dd(c3); raw spans -3..+4
    raw = $signed({5'b00000, c1}) + $signed({5'b00000, c2}) - $signed({5'b00000, s_q.c2z})
        + $signed({5'b00000, c3}) - $signed({4'b0000, s_q.c3z, 1'b0}) + $signed({5'b00000, s_q.c3zz});
    tot = raw + $signed({3'b000, s_q.res});
    // Excess above +3 is deferred, not dropped, so the average ratio stays exact
    if (!run) begin
      s_d.ofs = '0;
      s_d.res = '0;
      s_d.c2z = 1'b0;
      s_d.c3z = 1'b0;
      s_d.c3zz = 1'b0;
    end else begin
      if (tot > ffs_pkg::OFS_MAX) begin
        s_d.ofs = ffs_pkg::OFS_MAX[3:0];
        s_d.res = 3'(tot - ffs_pkg::OFS_MAX);
      end else begin
        s_d.ofs = tot[3:0];
        s_d.res = '0;
      end
      s_d.c2z  = c2;
      s_d.c3z  = c3;
      s_d.c3zz = s_q.c3z;
    end
    // Ratio = 80 + field + modulator offset
    s_d.ratio = 8'(ffs_pkg::NB_BASE + {2'b00, field} + {{4{s_q.ofs[3]}}, s_q.ofs});

    // Acquire trigger: a 1 arms, the following 0 starts a calibration
    if (s_q.acq[ffs_pkg::ACQ_BIT]) begin
      s_d.armed = 1'b1;
    end
    case (s_q.cal)
      ffs_pkg::FFS_IDLE: begin
        if (s_q.armed && !s_q.acq[ffs_pkg::ACQ_BIT]) begin
          s_d.armed   = 1'b0;
          s_d.cal     = ffs_pkg::FFS_CAL;
          s_d.cal_cnt = '0;
        end
      end
      ffs_pkg::FFS_CAL: begin
        // Band is picked from the ratio field at the end of the cycle
        if (s_q.cal_cnt == ffs_pkg::CAL_W'(ffs_pkg::CAL_CYCLES - 1)) begin
          band_prod = 9'(field) * 9'(ffs_pkg::BAND_MUL);
          s_d.band  = band_prod[ffs_pkg::BAND_SHIFT +: 5];
          s_d.cal   = ffs_pkg::FFS_IDLE;
        end else begin
          s_d.cal_cnt = s_q.cal_cnt + 1'b1;
        end
      end
      default: s_d.cal = ffs_pkg::FFS_IDLE;
    endcase

    // Bandwidth: widest-loop overrides spread request
    if (widest_loop_pin) begin
      s_d.bw = ffs_pkg::FFS_BW_250K;
    end else if (spread_request_pin) begin
      s_d.bw = ffs_pkg::FFS_BW_125K;
    end else begin
      s_d.bw = ffs_pkg::FFS_BW_50K;
    end
  end

  // State register; reset starts the power-up calibration
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q           <= '0;
      s_q.mod_ctl   <= ffs_pkg::RST_MOD_CTL;
      s_q.int_ratio <= ffs_pkg::RST_ZERO;
      s_q.cal       <= ffs_pkg::FFS_CAL;
      s_q.ratio     <= ffs_pkg::NB_BASE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata              = s_q.rdata;
  assign integer_feedback_ratio = s_q.ratio;
  assign modulator_offset       = s_q.ofs;
  assign modulator_active       = run;
  assign bleed_enable           = s_q.bleed[ffs_pkg::BLEED_BIT]; // Host keeps it consistent
  assign loop_bw_sel            = s_q.bw;
  assign cal_busy               = (s_q.cal == ffs_pkg::FFS_CAL);
  assign vco_band               = s_q.band;

  // Checks
  ofs_range_a: assert property (@(posedge clock) disable iff (rst)
    s_q.ofs >= -4'sd4 && s_q.ofs <= 4'sd3) else $error("modulator offset out of range");
  pd_quiet_a: assert property (@(posedge clock) disable iff (rst)
    !run ##1 !run |-> s_q.ofs == 4'sd0) else $error("offset moved while powered down");
  int_ratio_a: assert property (@(posedge clock) disable iff (rst)
    !run ##1 !run && $stable(field) |=> s_q.ratio == ffs_pkg::NB_BASE + {2'b00, $past(field)})
    else $error("integer ratio not base plus field");
  ratio_track_a: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> s_q.ratio == 8'(ffs_pkg::NB_BASE + {2'b00, $past(field)} + {{4{$past(s_q.ofs[3])}}, $past(s_q.ofs)}))
    else $error("ratio does not follow offset");
  bw_wide_a: assert property (@(posedge clock) disable iff (rst)
    widest_loop_pin |=> loop_bw_sel == ffs_pkg::FFS_BW_250K) else $error("widest loop not forced");
  bw_spread_a: assert property (@(posedge clock) disable iff (rst)
    !widest_loop_pin |=> loop_bw_sel == ($past(spread_request_pin) ? ffs_pkg::FFS_BW_125K : ffs_pkg::FFS_BW_50K))
    else $error("bandwidth select wrong");
  acq_start_a: assert property (@(posedge clock) disable iff (rst)
    s_q.cal == ffs_pkg::FFS_IDLE && s_q.armed && !s_q.acq[ffs_pkg::ACQ_BIT] |=> cal_busy)
    else $error("acquire trigger did not start calibration");
  cal_band_a: assert property (@(posedge clock) disable iff (rst)
    cal_busy ##1 !cal_busy |-> vco_band == 5'(({3'b000, $past(field)} * 9'(ffs_pkg::BAND_MUL)) >> ffs_pkg::BAND_SHIFT))
    else $error("band not taken from ratio");
  mod_nib_a: assert property (@(posedge clock) disable iff (rst)
    frac_mod[ffs_pkg::FW-1 -: 4] == s_q.frac_mod[3:0] && frac_num[3:0] == s_q.frac_mod[7:4])
    else $error("shared register split wrong");
endmodule : ffs_top

//--- verification/ffs_host_model.sv
// Host and pin model that drives the register port and the control pins
`timescale 1ns/100ps
module ffs_host_model (
  input  wire logic clock,
  output logic      reg_wr,
  output logic [2:0] reg_idx,
  output logic [7:0] reg_wdata,
  output logic      spread_request_pin,
  output logic      widest_loop_pin
);
  logic [3:0] mod_hi;
  // Everything idle at time zero
  initial begin
    reg_wr = 1'b0;
    reg_idx = 3'h0;
    reg_wdata = 8'h00;
    spread_request_pin = 1'b0;
    widest_loop_pin = 1'b0;
    mod_hi = 4'h0;
  end
  // One write: strobe for one edge, then data inverted so no stale byte lingers
  task automatic wr(input logic [2:0] idx, input logic [7:0] data);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_idx <= idx;
    reg_wdata <= data;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~data;
  endtask : wr
  // Select a register and wait out the registered read path
  task automatic sel(input logic [2:0] idx);
    @(posedge clock);
    reg_idx <= idx;
    repeat (2) @(posedge clock);
    #1;
  endtask : sel
  task automatic pins(input logic spread, input logic widest);
    @(posedge clock);
    spread_request_pin <= spread;
    widest_loop_pin <= widest;
  endtask : pins
  // Band calibration request after a ratio change
  task automatic acquire();
    wr(3'h6, 8'h01);
    wr(3'h6, 8'h00);
  endtask : acquire
  // Fractional mode; illegal modulus or numerator is never sent
  task automatic frac_mode(input logic [11:0] frac, input logic [11:0] md);
    if (md >= 12'd50 && frac < md) begin
      mod_hi = md[11:8];
      wr(3'h0, frac[11:4]);
      wr(3'h1, {frac[3:0], md[11:8]});
      wr(3'h2, md[7:0]);
      wr(3'h5, 8'h04);
      wr(3'h4, 8'h00);
    end
  endtask : frac_mode
  // Integer mode keeps the modulus, clears numerator, bleed and modulator
  task automatic int_mode();
    wr(3'h4, 8'h10);
    wr(3'h5, 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h1, {4'h0, mod_hi});
  endtask : int_mode
endmodule : ffs_host_model

//--- verification/tb_ffs_top.sv
// Self-checking bench for the fractional feedback modulator control block
`timescale 1ns/100ps
module tb_ffs_top;
  logic clock, rst, reg_wr, spread_request_pin, widest_loop_pin;
  logic modulator_active, bleed_enable, cal_busy;
  logic [2:0] reg_idx;
  logic [7:0] reg_wdata, reg_rdata, integer_feedback_ratio;
  logic signed [3:0] modulator_offset;
  logic [1:0] loop_bw_sel;
  logic [4:0] vco_band;
  int bad_count = 0;
  int cmp_count = 0;
  ffs_host_model host (.clock(clock), .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
    .spread_request_pin(spread_request_pin), .widest_loop_pin(widest_loop_pin));
  ffs_top DUT (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .spread_request_pin(spread_request_pin), .widest_loop_pin(widest_loop_pin),
    .integer_feedback_ratio(integer_feedback_ratio), .modulator_offset(modulator_offset),
    .modulator_active(modulator_active), .bleed_enable(bleed_enable), .loop_bw_sel(loop_bw_sel),
    .cal_busy(cal_busy), .vco_band(vco_band));
  // 20 MHz reference
  initial clock = 1'b0;
  always #25 clock = ~clock;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // Bounded wait for the calibration to finish
  task automatic wait_cal();
    for (int i = 0; i < 300 && cal_busy !== 1'b0; i++) @(posedge clock);
    #1;
    chk({7'h00, cal_busy}, 8'h00, "calibration end");
  endtask : wait_cal
  task automatic t_reset();
    @(posedge clock);
    #1;
    chk({7'h00, cal_busy}, 8'h01, "power-up calibration");
    chk(integer_feedback_ratio, 8'h50, "reset ratio");
    host.sel(3'h4);
    chk(reg_rdata, 8'h10, "modulator off at reset");
    wait_cal();
    chk({3'h0, vco_band}, 8'h00, "band for field 0");
    $display("test reset done");
  endtask : t_reset
  task automatic t_ratio();
    logic [7:0] f[2] = '{8'h13, 8'h33};
    foreach (f[i]) begin
      host.wr(3'h3, f[i]);
      repeat (2) @(posedge clock);
      #1;
      chk(integer_feedback_ratio, 8'h50 + f[i], "ratio");
      host.sel(3'h3);
      chk(reg_rdata, f[i], "ratio readback");
    end
    $display("test ratio done");
  endtask : t_ratio
  // New ratio 131, recalibrate, then a refused write to the status slot
  task automatic t_acq();
    host.acquire();
    for (int i = 0; i < 10 && cal_busy !== 1'b1; i++) @(posedge clock);
    #1;
    chk({7'h00, cal_busy}, 8'h01, "recalibration start");
    wait_cal();
    chk({3'h0, vco_band}, 8'h1F, "band for field 51");
    host.wr(3'h7, 8'hFF);
    host.sel(3'h7);
    chk(reg_rdata, 8'h1F, "status not writable");
    $display("test acquire done");
  endtask : t_acq
  task automatic t_bw();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      host.pins(c[0], c[1]);
      repeat (2) @(posedge clock);
      #1;
      chk({6'h00, loop_bw_sel}, c[1] ? 8'h02 : {7'h00, c[0]}, "loop bandwidth");
    end
    $display("test bandwidth done");
  endtask : t_bw
  // Ratio 99 plus 333/625: the offset over one modulus period must add up to the numerator within 4
  task automatic t_frac();
    logic signed [7:0] o, prv;
    int sum;
    sum = 0;
    host.wr(3'h3, 8'h13);
    host.frac_mode(12'd333, 12'd625);
    host.sel(3'h1);
    chk(reg_rdata, 8'hD2, "shared byte");
    chk({6'h00, modulator_active, bleed_enable}, 8'h03, "modulator and bleed on");
    prv = modulator_offset;
    for (int i = 0; i < 625; i++) begin
      @(posedge clock);
      #1;
      o = modulator_offset;
      if (o < -8'sd4 || o > 8'sd3) chk(o, 8'h00, "offset range");
      chk(integer_feedback_ratio, 8'd99 + prv, "ratio plus offset");
      sum += int'(o);
      prv = o;
    end
    chk({7'h00, sum >= 329 && sum <= 337}, 8'h01, "mean division");
    host.int_mode();
    repeat (3) @(posedge clock);
    #1;
    chk({6'h00, modulator_active, bleed_enable}, 8'h00, "integer mode");
    chk(integer_feedback_ratio, 8'd99, "integer ratio");
    $display("test fractional done");
  endtask : t_frac
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Tests need about 1100 cycles; the limit of 20000 cycles is far beyond that
  initial begin
    #(20000 * 50);
    bad_count++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    final_report();
  end
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_ratio();
    t_acq();
    t_bw();
    t_frac();
    final_report();
  end
endmodule : tb_ffs_top
